/* bccu_defs.svh */
// Constants for the upper chip control register block.
//
// Operation
// - Bit 15 clear sends a credit update per two freed credits, set sends one per freed credit, reset clear.
// - Bit 16 is set by hardware when the retry counter expires and cleared by software writing one.
// - Field 18:17 picks the retry limit: unlimited, 256, 64K or 2G retries, reset 00.
// - Bit 19 set disables the discard timer, and so does bridge control bit 27 on its own, reset clear.
// - Bit 20 set makes the discard timer expire after 64 clocks, else bridge control bit 24 or 25 decides.
// - Field 22:21 sets the configuration retry timer to 25us, 0.5ms, 5ms or 25ms, reset 01.
// - Bit 23 set forbids out-of-order completion of delayed transactions, reset clear.
// - Field 25:24 sets the completion timeout to 50us, 1ms, 10ms or 50ms, reset 01.
// - Bit 26 clear maps forwarded memory traffic to class zero, set maps it to field 29:27.
// - Field 29:27 holds the isochronous traffic class and resets to 001.
// - Bit 30 loops serial transmit to receive only under the test strap pattern and is read-only in forward mode.
// - Bit 31 set locks out primary configuration access with a retry status or a target retry.
// - Bit 31 resets to one when test_strap_zero is high.
`ifndef BCCU_DEFS_SVH
`define BCCU_DEFS_SVH
`define BCCU_OFFSET        8'h40
`define BCCU_B_FC_SINGLE   15
`define BCCU_B_RETRY_EXP   16
`define BCCU_F_RETRY_LO    17
`define BCCU_F_RETRY_HI    18
`define BCCU_B_DISC_DIS    19
`define BCCU_B_DISC_SHORT  20
`define BCCU_F_CRS_LO      21
`define BCCU_F_CRS_HI      22
`define BCCU_B_DT_ORDER    23
`define BCCU_F_CTO_LO      24
`define BCCU_F_CTO_HI      25
`define BCCU_B_ISO_EN      26
`define BCCU_F_TC_LO       27
`define BCCU_F_TC_HI       29
`define BCCU_B_LOOPBACK    30
`define BCCU_B_LOCKOUT     31
`define BCCU_BC_DISC_DIS   27
`define BCCU_BC_DISC_FWD   24
`define BCCU_BC_DISC_REV   25
`define BCCU_RST_CRS       2'h1
`define BCCU_RST_CTO       2'h1
`define BCCU_RST_TC        3'h1
`define BCCU_LIM_256       32'h0000_0100
`define BCCU_LIM_64K       32'h0001_0000
`define BCCU_LIM_2G        32'h8000_0000
`define BCCU_DISC_SHORT    10'h040
`define BCCU_DISC_LONG     10'h3FF
`define BCCU_DISC_DEF      10'h0FF
`define BCCU_CLK_MHZ       250
`define BCCU_CRS0_US       25
`define BCCU_CRS1_US       500
`define BCCU_CRS2_US       5000
`define BCCU_CRS3_US       25000
`define BCCU_CTO0_US       50
`define BCCU_CTO1_US       1000
`define BCCU_CTO2_US       10000
`define BCCU_CTO3_US       50000
`endif

/* bccu_pkg.sv */
// Types shared by the upper chip control register block.
package bccu_pkg;
  typedef enum logic [1:0] {
    BCCU_CFG_OPEN  = 2'h0,
    BCCU_CFG_CRS   = 2'h1,
    BCCU_CFG_RETRY = 2'h3
  } bccu_cfg_ans_e;
  typedef logic [2:0] bccu_tc_t;
endpackage

/* bccu_retry_if.sv */
// Interface between the register and the retry counter.
`timescale 1ns/1ps
interface bccu_retry_if;
  logic [1:0] limit_sel;
  logic       attempt;
  logic       done;
  logic       expired;
  modport reg_side (output limit_sel, output attempt, output done, input expired);
  modport cnt_side (input limit_sel, input attempt, input done, output expired);
endinterface

/* bccu_retry_cnt.sv */
// Retry counter with selectable expiry limit.
`timescale 1ns/1ps
`include "bccu_defs.svh"
module bccu_retry_cnt
(
  input  wire logic   clk,
  input  wire logic   rst_b,
  bccu_retry_if.cnt_side rif
);
  import bccu_pkg::*;
  typedef struct packed
  {
    logic [31:0] count;
    logic        expired;
  } bccu_rc_s;
  bccu_rc_s st_q;
  bccu_rc_s st_d;
  function automatic logic [31:0] bccu_limit(input logic [1:0] sel);
    unique case (sel)
      2'h1: bccu_limit = `BCCU_LIM_256;
      2'h2: bccu_limit = `BCCU_LIM_64K;
      2'h3: bccu_limit = `BCCU_LIM_2G;
      default: bccu_limit = 32'h0000_0000;
    endcase
  endfunction
  always_comb
  begin
    st_d = st_q;
    st_d.expired = 1'b0;
    if (rif.done)
    begin
      st_d.count = 32'h0000_0000;
    end
    else if (rif.attempt)
    begin
      if (rif.limit_sel != 2'h0 && st_q.count + 32'h1 >= bccu_limit(rif.limit_sel))
      begin
        st_d.expired = 1'b1;
        st_d.count = 32'h0000_0000;
      end
      else
      begin
        st_d.count = st_q.count + 32'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign rif.expired = st_q.expired;
  chk_unlimited_never_expires : assert property (@(posedge clk) disable iff (!rst_b)
    $past(rif.limit_sel) == 2'h0 |-> !rif.expired) else $error("Retry expired with no limit.");
  chk_limit_256_count : assert property (@(posedge clk) disable iff (!rst_b)
    rif.expired && $past(rif.limit_sel) == 2'h1 |-> $past(st_q.count) == 32'h0000_00FF)
    else $error("Retry expiry not at 256.");
endmodule

/* bccu_timer_sel.sv */
// Converts timeout field codes into clock counts.
`timescale 1ns/1ps
`include "bccu_defs.svh"
module bccu_timer_sel
(
  input  wire logic [1:0]  crs_sel,
  input  wire logic [1:0]  cto_sel,
  output logic      [31:0] crs_cycles,
  output logic      [31:0] cto_cycles
);
  import bccu_pkg::*;
  function automatic logic [31:0] bccu_us2cyc(input int us);
    bccu_us2cyc = 32'(us * `BCCU_CLK_MHZ);
  endfunction
  always_comb
  begin
    unique case (crs_sel)
      2'h0: crs_cycles = bccu_us2cyc(`BCCU_CRS0_US);
      2'h1: crs_cycles = bccu_us2cyc(`BCCU_CRS1_US);
      2'h2: crs_cycles = bccu_us2cyc(`BCCU_CRS2_US);
      2'h3: crs_cycles = bccu_us2cyc(`BCCU_CRS3_US);
    endcase
    unique case (cto_sel)
      2'h0: cto_cycles = bccu_us2cyc(`BCCU_CTO0_US);
      2'h1: cto_cycles = bccu_us2cyc(`BCCU_CTO1_US);
      2'h2: cto_cycles = bccu_us2cyc(`BCCU_CTO2_US);
      2'h3: cto_cycles = bccu_us2cyc(`BCCU_CTO3_US);
    endcase
  end
endmodule

/* bccu_top.sv */
// Upper half of the chip control register and the controls it drives.
`timescale 1ns/1ps
`include "bccu_defs.svh"
module bccu_top
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   cfg_wr,
  input  wire logic [7:0]             cfg_addr,
  input  wire logic [31:0]            cfg_wdata,
  input  wire logic [3:0]             cfg_be,
  output logic      [31:0]            cfg_rdata,
  input  wire logic                   cfg_req,
  input  wire logic                   cfg_from_primary,
  output bccu_pkg::bccu_cfg_ans_e     cfg_answer,
  input  wire logic                   reverse_mode,
  input  wire logic                   test_strap_zero,
  input  wire logic                   test_strap_one,
  input  wire logic                   test_strap_two,
  input  wire logic                   mask_input,
  input  wire logic                   reverse_select,
  input  wire logic [31:0]            bridge_ctrl,
  input  wire logic                   credit_freed,
  output logic                        credit_update,
  input  wire logic                   retry_attempt,
  input  wire logic                   retry_done,
  output logic                        discard_enable,
  output logic      [9:0]             discard_clocks,
  output logic      [31:0]            crs_cycles,
  output logic      [31:0]            cto_cycles,
  output logic                        dt_in_order,
  output bccu_pkg::bccu_tc_t          tx_class,
  output logic                        serial_loopback
);
  import bccu_pkg::*;
  typedef struct packed
  {
    logic        fc_single;
    logic        retry_exp;
    logic [1:0]  retry_lim;
    logic        disc_dis;
    logic        disc_short;
    logic [1:0]  crs_sel;
    logic        dt_order;
    logic [1:0]  cto_sel;
    logic        iso_en;
    logic [2:0]  tc;
    logic        loopback;
    logic        lockout;
    logic        strap_done;
    logic        credit_half;
    logic        credit_update;
    logic [31:0] rdata;
    bccu_cfg_ans_e answer;
  } bccu_top_s;
  bccu_top_s st_q;
  bccu_top_s st_d;
  logic      hit;
  logic      wr_hi;
  logic      wr_top;
  logic      strap_loop;
  bccu_retry_if rif ();
  assign hit = cfg_addr == `BCCU_OFFSET;
  assign wr_hi = cfg_wr && hit && cfg_be[2];
  assign wr_top = cfg_wr && hit && cfg_be[3];
  assign strap_loop = !test_strap_zero && test_strap_one && test_strap_two && mask_input && reverse_select;
  assign rif.limit_sel = st_q.retry_lim;
  assign rif.attempt = retry_attempt;
  assign rif.done = retry_done;
  bccu_retry_cnt u_retry
  (
    .clk   (clk),
    .rst_b (rst_b),
    .rif   (rif)
  );
  bccu_timer_sel u_timer
  (
    .crs_sel    (st_q.crs_sel),
    .cto_sel    (st_q.cto_sel),
    .crs_cycles (crs_cycles),
    .cto_cycles (cto_cycles)
  );
  always_comb
  begin
    st_d = st_q;
    st_d.credit_update = 1'b0;
    if (!st_q.strap_done)
    begin
      st_d.strap_done = 1'b1;
      st_d.lockout = test_strap_zero;
    end
    if (cfg_wr && hit && cfg_be[1])
      st_d.fc_single = cfg_wdata[`BCCU_B_FC_SINGLE];
    if (wr_hi)
    begin
      st_d.retry_lim = cfg_wdata[`BCCU_F_RETRY_HI:`BCCU_F_RETRY_LO];
      st_d.disc_dis = cfg_wdata[`BCCU_B_DISC_DIS];
      st_d.disc_short = cfg_wdata[`BCCU_B_DISC_SHORT];
      st_d.crs_sel = cfg_wdata[`BCCU_F_CRS_HI:`BCCU_F_CRS_LO];
      st_d.dt_order = cfg_wdata[`BCCU_B_DT_ORDER];
      if (cfg_wdata[`BCCU_B_RETRY_EXP])
        st_d.retry_exp = 1'b0;
    end
    if (rif.expired)
      st_d.retry_exp = 1'b1;
    if (wr_top)
    begin
      st_d.cto_sel = cfg_wdata[`BCCU_F_CTO_HI:`BCCU_F_CTO_LO];
      st_d.iso_en = cfg_wdata[`BCCU_B_ISO_EN];
      st_d.tc = cfg_wdata[`BCCU_F_TC_HI:`BCCU_F_TC_LO];
      if (reverse_mode)
        st_d.loopback = cfg_wdata[`BCCU_B_LOOPBACK];
      st_d.lockout = cfg_wdata[`BCCU_B_LOCKOUT];
    end
    if (credit_freed)
    begin
      if (st_q.fc_single || st_q.credit_half)
      begin
        st_d.credit_update = 1'b1;
        st_d.credit_half = 1'b0;
      end
      else
      begin
        st_d.credit_half = 1'b1;
      end
    end
    st_d.rdata = 32'h0000_0000;
    if (hit)
    begin
      st_d.rdata[`BCCU_B_FC_SINGLE] = st_q.fc_single;
      st_d.rdata[`BCCU_B_RETRY_EXP] = st_q.retry_exp;
      st_d.rdata[`BCCU_F_RETRY_HI:`BCCU_F_RETRY_LO] = st_q.retry_lim;
      st_d.rdata[`BCCU_B_DISC_DIS] = st_q.disc_dis;
      st_d.rdata[`BCCU_B_DISC_SHORT] = st_q.disc_short;
      st_d.rdata[`BCCU_F_CRS_HI:`BCCU_F_CRS_LO] = st_q.crs_sel;
      st_d.rdata[`BCCU_B_DT_ORDER] = st_q.dt_order;
      st_d.rdata[`BCCU_F_CTO_HI:`BCCU_F_CTO_LO] = st_q.cto_sel;
      st_d.rdata[`BCCU_B_ISO_EN] = st_q.iso_en;
      st_d.rdata[`BCCU_F_TC_HI:`BCCU_F_TC_LO] = st_q.tc;
      st_d.rdata[`BCCU_B_LOOPBACK] = st_q.loopback;
      st_d.rdata[`BCCU_B_LOCKOUT] = st_q.lockout;
    end
    st_d.answer = BCCU_CFG_OPEN;
    if (cfg_req && cfg_from_primary && st_q.lockout)
      st_d.answer = reverse_mode ? BCCU_CFG_RETRY : BCCU_CFG_CRS;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.crs_sel <= `BCCU_RST_CRS;
      st_q.cto_sel <= `BCCU_RST_CTO;
      st_q.tc <= `BCCU_RST_TC;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign cfg_rdata = st_q.rdata;
  assign cfg_answer = st_q.answer;
  assign credit_update = st_q.credit_update;
  assign discard_enable = !st_q.disc_dis && !bridge_ctrl[`BCCU_BC_DISC_DIS];
  assign discard_clocks = st_q.disc_short ? `BCCU_DISC_SHORT :
    (bridge_ctrl[reverse_mode ? `BCCU_BC_DISC_REV : `BCCU_BC_DISC_FWD] ? `BCCU_DISC_LONG : `BCCU_DISC_DEF);
  assign dt_in_order = st_q.dt_order;
  assign tx_class = st_q.iso_en ? st_q.tc : 3'h0;
  assign serial_loopback = st_q.loopback && strap_loop;
  chk_lock_answer : assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req && cfg_from_primary && st_q.lockout && !reverse_mode |=> cfg_answer == BCCU_CFG_CRS)
    else $error("Locked primary access not given retry status.");
  chk_lock_rev : assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req && cfg_from_primary && st_q.lockout && reverse_mode |=> cfg_answer == BCCU_CFG_RETRY)
    else $error("Locked primary access not given target retry.");
  chk_sec_open : assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_from_primary |=> cfg_answer == BCCU_CFG_OPEN) else $error("Secondary access refused.");
  chk_exp_sticky : assert property (@(posedge clk) disable iff (!rst_b)
    rif.expired |=> st_q.retry_exp) else $error("Expiry flag not set.");
  chk_exp_hold : assert property (@(posedge clk) disable iff (!rst_b)
    st_q.retry_exp && !wr_hi |=> st_q.retry_exp) else $error("Expiry flag dropped.");
  chk_tc_zero : assert property (@(posedge clk) disable iff (!rst_b)
    !st_q.iso_en |-> tx_class == 3'h0) else $error("Class not zero.");
  chk_fwd_loop_ro : assert property (@(posedge clk) disable iff (!rst_b)
    !reverse_mode |=> st_q.loopback == $past(st_q.loopback)) else $error("Loopback written in forward.");
  chk_strap_lock : assert property (@(posedge clk) disable iff (!rst_b)
    !st_q.strap_done |=> st_q.lockout == ($past(wr_top) ? $past(cfg_wdata[`BCCU_B_LOCKOUT]) : $past(test_strap_zero)))
    else $error("Lockout strap not caught.");
  sequence s_first_credit;
    credit_freed && !st_q.fc_single && !st_q.credit_half;
  endsequence
  sequence s_no_update;
    !credit_update;
  endsequence
  chk_fc_pair : assert property (@(posedge clk) disable iff (!rst_b)
    s_first_credit |=> s_no_update) else $error("Update after one credit in paired mode.");
endmodule

/* bccu_far_end.sv */
// Far side model that frees flow control credits and repeats retried transfers on command.
`timescale 1ns/1ps
module bccu_far_end
(
  input  wire logic       clk,
  input  wire logic       kind,
  input  wire logic [8:0] count,
  input  wire logic       start,
  output logic            busy,
  output logic            credit_freed,
  output logic            retry_attempt
);
  int left = 0;
  initial
  begin
    credit_freed  = 1'b0;
    retry_attempt = 1'b0;
  end
  assign busy = (left != 0) || start;
  // Kind low frees one credit per cycle, kind high makes one retry attempt per cycle.
  always @(negedge clk)
  begin
    credit_freed  <= 1'b0;
    retry_attempt <= 1'b0;
    if (left > 0)
    begin
      credit_freed  <= !kind;
      retry_attempt <= kind;
      left = left - 1;
    end
    else if (start)
    begin
      left = count;
    end
  end
endmodule

/* bridge_chip_control_upper_test.sv */
// Self-checking bench for the upper chip control register block.
`timescale 1ns/1ps
module bridge_chip_control_upper_test;
  import bccu_pkg::*;
  localparam logic [31:0] RST = 32'h0920_0000;
  localparam int CRS_US [4] = '{25, 500, 5000, 25000};
  localparam int CTO_US [4] = '{50, 1000, 10000, 50000};
  logic clk = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0, cfg_req = 1'b0, prim = 1'b0;
  logic rev = 1'b0, retry_done = 1'b0, kind = 1'b0, start = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [4:0]  straps = 5'h1F;
  logic [8:0]  cnt = 9'h000;
  logic [31:0] cfg_wdata = 32'h0, bctl = 32'h0, rdat, d;
  logic [1:0]  k;
  wire logic credit_freed, retry_attempt, busy, credit_update, discard_enable, dt_in_order, serial_loopback;
  wire logic [31:0] cfg_rdata, crs_cycles, cto_cycles;
  wire logic [9:0] discard_clocks;
  bccu_cfg_ans_e cfg_answer;
  bccu_tc_t tx_class;
  int err_total = 0, compares = 0, cyc = 0, upd = 0;
  always #2 clk = !clk;
  bccu_top dut (.clk, .rst_b, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata, .cfg_req,
    .cfg_from_primary(prim), .cfg_answer, .reverse_mode(rev), .test_strap_zero(straps[0]),
    .test_strap_one(straps[1]), .test_strap_two(straps[2]), .mask_input(straps[3]),
    .reverse_select(straps[4]), .bridge_ctrl(bctl), .credit_freed, .credit_update, .retry_attempt,
    .retry_done, .discard_enable, .discard_clocks, .crs_cycles, .cto_cycles, .dt_in_order, .tx_class,
    .serial_loopback);
  bccu_far_end far_end (.clk, .kind, .count(cnt), .start, .busy, .credit_freed, .retry_attempt);
  task automatic wrap_up;
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic reset(input logic z);
    straps[0] = z;
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic wr(input logic [31:0] v, input logic [3:0] be);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = 8'h40;
    cfg_wdata = v;
    cfg_be = be;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk);
    cfg_addr = a;
    @(negedge clk);
    v = cfg_rdata;
  endtask
  task automatic req(input logic p, input logic [31:0] exp);
    @(negedge clk);
    cfg_req = 1'b1;
    prim = p;
    @(negedge clk);
    cfg_req = 1'b0;
    chk(cfg_answer, exp);
  endtask
  task automatic far(input logic kd, input int n);
    @(negedge clk);
    kind <= kd;
    cnt <= n[8:0];
    start <= 1'b1;
    @(negedge clk);
    start <= 1'b0;
    #1;
    while (busy === 1'b1)
    begin
      @(negedge clk);
      #1;
    end
    repeat (3) @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (credit_update === 1'b1)
      upd++;
    if (cyc == 6000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    reset(1'b0);
    rd(8'h40, rdat);
    chk(rdat, RST);
    reset(1'b1);
    rd(8'h40, rdat);
    chk(rdat, RST | 32'h8000_0000);
    chk(crs_cycles, 125000);
    chk(cto_cycles, 250000);
    chk(tx_class, 32'h0);
    rd(8'h44, rdat);
    chk(rdat, 32'h0);
    req(1'b1, 32'h1);
    req(1'b0, 32'h0);
    rev = 1'b1;
    req(1'b1, 32'h3);
    rev = 1'b0;
    wr(32'h0, 4'h8);
    req(1'b1, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      k = i;
      d = (i << 21) | (i << 24) | (i << 17) | (k[0] << 23) | (k[0] << 19) | (k[1] << 20) | (k[0] << 15);
      wr(d | 32'h2C00_0000, 4'hE);
      rd(8'h40, rdat);
      chk(rdat, d | 32'h2C00_0000);
      chk(crs_cycles, CRS_US[i] * 250);
      chk(cto_cycles, CTO_US[i] * 250);
      chk(dt_in_order, k[0]);
      chk(discard_enable, !k[0]);
      if (k[1])
        chk(discard_clocks, 32'h40);
      else
        chk(discard_clocks, 32'hFF);
      chk(tx_class, 32'h5);
    end
    wr(32'h2800_0000, 4'hE);
    chk(tx_class, 32'h0);
    bctl = 32'h0900_0000;
    @(negedge clk);
    chk(discard_enable, 32'h0);
    chk(discard_clocks, 32'h3FF);
    bctl = 32'h0200_0000;
    @(negedge clk);
    chk(discard_enable, 32'h1);
    chk(discard_clocks, 32'hFF);
    bctl = 32'h0;
    upd = 0;
    far(1'b0, 4);
    chk(upd, 2);
    wr(32'h0000_8000, 4'hE);
    upd = 0;
    far(1'b0, 3);
    chk(upd, 3);
    wr(32'h0002_0000, 4'hE);
    far(1'b1, 200);
    @(negedge clk);
    retry_done = 1'b1;
    @(negedge clk);
    retry_done = 1'b0;
    far(1'b1, 255);
    rd(8'h40, rdat);
    chk(rdat, 32'h0002_0000);
    far(1'b1, 1);
    rd(8'h40, rdat);
    chk(rdat, 32'h0003_0000);
    wr(32'h0003_0000, 4'h4);
    rd(8'h40, rdat);
    chk(rdat, 32'h0002_0000);
    wr(32'h4000_0000, 4'hE);
    rd(8'h40, rdat);
    chk(rdat, 32'h0);
    rev = 1'b1;
    straps = 5'h1E;
    wr(32'h4000_0000, 4'hE);
    rd(8'h40, rdat);
    chk(rdat, 32'h4000_0000);
    chk(serial_loopback, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      straps = 5'h1E ^ (5'h01 << i);
      repeat (2) @(negedge clk);
      chk(serial_loopback, 32'h0);
    end
    wrap_up();
  end
endmodule
